/* File: rtl/synth_cfg_pkg.sv */
// Shared constants and types for the synthesizer configuration bank
package synth_cfg_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int FRAC_W = 25;
    localparam int INT_W  = 12;
    localparam int PUMP_W = 4;
    localparam int RDIV_W = 5;
    localparam int RATIO_W = 6;
    localparam int LEVEL_W = 16;
    localparam int SEL_W  = 4;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_FRAC0  = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_FRAC1  = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_FRAC2  = 8'h02;
    localparam logic [ADDR_W-1:0] ADDR_FRAC3  = 8'h03;
    localparam logic [ADDR_W-1:0] ADDR_RDIVEN = 8'h05;
    localparam logic [ADDR_W-1:0] ADDR_INTLO  = 8'h06;
    localparam logic [ADDR_W-1:0] ADDR_INTHI  = 8'h07;
    localparam logic [ADDR_W-1:0] ADDR_PUMP   = 8'h09;
    localparam logic [ADDR_W-1:0] ADDR_REFCTL = 8'h0A;

    // Field positions
    localparam int RDIVEN_BIT  = 4;
    localparam int HALVER_BIT  = 6;
    localparam int DOUBLER_BIT = 5;

    // Reset values and decode figures
    localparam logic [DATA_W-1:0]  BYTE_ZERO     = 8'h00;
    localparam logic [RDIV_W-1:0]  RDIV_ZERO     = 5'h00;
    localparam logic [RATIO_W-1:0] RATIO_ZERO_CODE = 6'h20;
    localparam logic [RATIO_W-1:0] RATIO_BYPASS  = 6'h01;
    localparam logic [LEVEL_W-1:0] PUMP_STEP_100NA = 16'h0C35;
    localparam logic [LEVEL_W-1:0] LEVEL_ONE     = 16'h0001;

    // Test output selector codes
    typedef enum logic [SEL_W-1:0] {
        SEL_HIGHZ    = 4'b0000,
        SEL_HIGH     = 4'b0001,
        SEL_LOW      = 4'b0010,
        SEL_REF_HALF = 4'b1101,
        SEL_FB_HALF  = 4'b1110
    } test_sel_t;

    // Buffered configuration set, shadow and active copies share it
    typedef struct packed {
        logic [FRAC_W-1:0] frac;
        logic [INT_W-1:0]  integ;
        logic [PUMP_W-1:0] pump;
        logic              rdiv_en;
        logic [RDIV_W-1:0] rdiv;
        logic              halver;
        logic              doubler;
    } cfg_t;

    localparam cfg_t CFG_RESET = '0;

    // Host register access group
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;
endpackage : synth_cfg_pkg

/* File: rtl/test_output_mux.sv */
// Test output pin selector with halved reference and feedback clocks
`timescale 1ns/1ps
module test_output_mux (
    input  wire logic                            sys_clk,
    input  wire logic                            rst,
    input  wire logic [synth_cfg_pkg::SEL_W-1:0] sel,
    input  wire logic                            ref_clk_in,
    input  wire logic                            feedback_divider_clock,
    output logic                                 test_out,
    output logic                                 test_out_oe
);
    import synth_cfg_pkg::*;

    typedef struct packed {
        logic ref_d;
        logic fb_d;
        logic ref_half;
        logic fb_half;
        logic pin;
        logic oe;
    } mux_state_t;

    mux_state_t state_ff;
    mux_state_t nxt_state;

    // Halved clocks toggle on sampled rising edges; inputs are synchronous
    always_comb begin
        nxt_state = state_ff;
        nxt_state.ref_d = ref_clk_in;
        nxt_state.fb_d  = feedback_divider_clock;
        if (ref_clk_in && !state_ff.ref_d) begin
            nxt_state.ref_half = !state_ff.ref_half;
        end
        if (feedback_divider_clock && !state_ff.fb_d) begin
            nxt_state.fb_half = !state_ff.fb_half;
        end
        // Unlisted codes float the pin rather than guess a source
        case (sel)
            SEL_HIGH: begin
                nxt_state.pin = 1'b1;
                nxt_state.oe  = 1'b1;
            end
            SEL_LOW: begin
                nxt_state.pin = 1'b0;
                nxt_state.oe  = 1'b1;
            end
            SEL_REF_HALF: begin
                nxt_state.pin = nxt_state.ref_half;
                nxt_state.oe  = 1'b1;
            end
            SEL_FB_HALF: begin
                nxt_state.pin = nxt_state.fb_half;
                nxt_state.oe  = 1'b1;
            end
            default: begin
                nxt_state.pin = 1'b0;
                nxt_state.oe  = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign test_out    = state_ff.pin;
    assign test_out_oe = state_ff.oe;
endmodule : test_output_mux

/* File: rtl/synth_divider_config_bank.sv */
// Double-buffered configuration register bank of the fractional-N synthesizer
`timescale 1ns/1ps
module synth_divider_config_bank (
    input  wire logic                              sys_clk,
    input  wire logic                              rst,
    input  wire synth_cfg_pkg::reg_req_t           reg_req,
    output logic [synth_cfg_pkg::DATA_W-1:0]       reg_rdata,
    output logic                                   reg_rvalid,
    output logic [synth_cfg_pkg::FRAC_W-1:0]       frac_word,
    output logic [synth_cfg_pkg::INT_W-1:0]        int_word,
    output logic [synth_cfg_pkg::PUMP_W-1:0]       pump_code,
    output logic [synth_cfg_pkg::LEVEL_W-1:0]      pump_level_100na,
    output logic                                   ref_div_enable,
    output logic [synth_cfg_pkg::RDIV_W-1:0]       ref_div_code,
    output logic [synth_cfg_pkg::RATIO_W-1:0]      ref_div_ratio,
    output logic                                   ref_halver_en,
    output logic                                   ref_doubler_en,
    output logic                                   cfg_update,
    input  wire logic                              ref_clk_in,
    input  wire logic                              feedback_divider_clock,
    output logic                                   test_out,
    output logic                                   test_out_oe
);
    import synth_cfg_pkg::*;

    typedef struct packed {
        cfg_t               shadow;
        cfg_t               active;
        logic [SEL_W-1:0]   test_sel;
        logic [DATA_W-1:0]  rdata;
        logic               rvalid;
        logic               update;
        logic [LEVEL_W-1:0] level;
        logic [RATIO_W-1:0] ratio;
    } bank_state_t;

    bank_state_t state_ff;
    bank_state_t nxt_state;

    // Shadow update, commit on byte zero, readback and derived decodes
    always_comb begin
        nxt_state        = state_ff;
        nxt_state.update = 1'b0;
        nxt_state.rvalid = reg_req.rd;
        // Readback shows shadow contents; reserved bits and holes read zero
        nxt_state.rdata  = BYTE_ZERO;
        if (reg_req.rd) begin
            case (reg_req.addr)
                ADDR_FRAC0:  nxt_state.rdata = state_ff.shadow.frac[7:0];
                ADDR_FRAC1:  nxt_state.rdata = state_ff.shadow.frac[15:8];
                ADDR_FRAC2:  nxt_state.rdata = state_ff.shadow.frac[23:16];
                ADDR_FRAC3:  nxt_state.rdata = {7'h00, state_ff.shadow.frac[24]};
                ADDR_RDIVEN: begin
                    nxt_state.rdata = BYTE_ZERO;
                    nxt_state.rdata[RDIVEN_BIT] = state_ff.shadow.rdiv_en;
                end
                ADDR_INTLO:  nxt_state.rdata = state_ff.shadow.integ[7:0];
                ADDR_INTHI:  nxt_state.rdata = {state_ff.test_sel,
                                                state_ff.shadow.integ[11:8]};
                ADDR_PUMP:   nxt_state.rdata = {state_ff.shadow.pump, 4'h0};
                ADDR_REFCTL: nxt_state.rdata = {1'b0, state_ff.shadow.halver,
                                                state_ff.shadow.doubler,
                                                state_ff.shadow.rdiv};
                default:     nxt_state.rdata = BYTE_ZERO;
            endcase
        end
        // Reserved bit writes are dropped, so a careless host cannot set them
        if (reg_req.wr) begin
            case (reg_req.addr)
                ADDR_FRAC0:  nxt_state.shadow.frac[7:0]   = reg_req.wdata;
                ADDR_FRAC1:  nxt_state.shadow.frac[15:8]  = reg_req.wdata;
                ADDR_FRAC2:  nxt_state.shadow.frac[23:16] = reg_req.wdata;
                ADDR_FRAC3:  nxt_state.shadow.frac[24]    = reg_req.wdata[0];
                ADDR_RDIVEN: nxt_state.shadow.rdiv_en = reg_req.wdata[RDIVEN_BIT];
                ADDR_INTLO:  nxt_state.shadow.integ[7:0]  = reg_req.wdata;
                ADDR_INTHI: begin
                    nxt_state.shadow.integ[11:8] = reg_req.wdata[3:0];
                    nxt_state.test_sel           = reg_req.wdata[7:4];
                end
                ADDR_PUMP:   nxt_state.shadow.pump = reg_req.wdata[7:4];
                ADDR_REFCTL: begin
                    nxt_state.shadow.halver  = reg_req.wdata[HALVER_BIT];
                    nxt_state.shadow.doubler = reg_req.wdata[DOUBLER_BIT];
                    nxt_state.shadow.rdiv    = reg_req.wdata[4:0];
                end
                default: ;
            endcase
            // Commit includes the byte being written in this same cycle
            if (reg_req.addr == ADDR_FRAC0) begin
                nxt_state.active = nxt_state.shadow;
                nxt_state.update = 1'b1;
            end
        end
        // Pump level in 100 nA units: (code + 1) steps of 312.5 uA
        nxt_state.level = LEVEL_W'(({12'h000, nxt_state.active.pump} + LEVEL_ONE)
                                   * PUMP_STEP_100NA);
        // Effective divider ratio; code zero means the full 32
        if (!nxt_state.active.rdiv_en) begin
            nxt_state.ratio = RATIO_BYPASS;
        end else if (nxt_state.active.rdiv == RDIV_ZERO) begin
            nxt_state.ratio = RATIO_ZERO_CODE;
        end else begin
            nxt_state.ratio = {1'b0, nxt_state.active.rdiv};
        end
    end

    // State register; all buffered fields default to zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_ff        <= '0;
            state_ff.shadow <= CFG_RESET;
            state_ff.active <= CFG_RESET;
            state_ff.level  <= PUMP_STEP_100NA;
            state_ff.ratio  <= RATIO_BYPASS;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Outputs straight from the state register
    assign reg_rdata        = state_ff.rdata;
    assign reg_rvalid       = state_ff.rvalid;
    assign frac_word        = state_ff.active.frac;
    assign int_word         = state_ff.active.integ;
    assign pump_code        = state_ff.active.pump;
    assign pump_level_100na = state_ff.level;
    assign ref_div_enable   = state_ff.active.rdiv_en;
    assign ref_div_code     = state_ff.active.rdiv;
    assign ref_div_ratio    = state_ff.ratio;
    assign ref_halver_en    = state_ff.active.halver;
    assign ref_doubler_en   = state_ff.active.doubler;
    assign cfg_update       = state_ff.update;

    // Test pin follows the selector live; it is not double-buffered
    test_output_mux u_test_mux (
        .sys_clk                (sys_clk),
        .rst                    (rst),
        .sel                    (state_ff.test_sel),
        .ref_clk_in             (ref_clk_in),
        .feedback_divider_clock (feedback_divider_clock),
        .test_out               (test_out),
        .test_out_oe            (test_out_oe)
    );
endmodule : synth_divider_config_bank

/* File: sim/cfg_bank_checker.sv */
// Port-level assertions for the synthesizer configuration bank
`timescale 1ns/1ps
module cfg_bank_checker (
    input wire logic                              sys_clk,
    input wire logic                              rst,
    input wire synth_cfg_pkg::reg_req_t           reg_req,
    input wire logic [synth_cfg_pkg::DATA_W-1:0]  reg_rdata,
    input wire logic                              reg_rvalid,
    input wire logic [synth_cfg_pkg::FRAC_W-1:0]  frac_word,
    input wire logic [synth_cfg_pkg::INT_W-1:0]   int_word,
    input wire logic [synth_cfg_pkg::PUMP_W-1:0]  pump_code,
    input wire logic [synth_cfg_pkg::LEVEL_W-1:0] pump_level_100na,
    input wire logic                              ref_div_enable,
    input wire logic [synth_cfg_pkg::RDIV_W-1:0]  ref_div_code,
    input wire logic [synth_cfg_pkg::RATIO_W-1:0] ref_div_ratio,
    input wire logic                              cfg_update,
    input wire logic                              test_out,
    input wire logic                              test_out_oe
);
    import synth_cfg_pkg::*;
    logic commit;
    logic sel_high;
    // Decoded host strobes; the pin check needs the selector left alone for a cycle
    assign commit   = reg_req.wr && reg_req.addr == ADDR_FRAC0;
    assign sel_high = reg_req.wr && reg_req.addr == ADDR_INTHI && reg_req.wdata[7:4] == 4'h1;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_read_answer: assert property (reg_req.rd |=> reg_rvalid)
        else $error("read got no answer");
    a_no_stray_answer: assert property (!reg_req.rd |=> !reg_rvalid)
        else $error("answer without read");
    a_idle_data_zero: assert property (!reg_rvalid |-> reg_rdata == 8'h00)
        else $error("read data not zero when idle");
    a_commit_pulse: assert property (cfg_update == $past(commit))
        else $error("update pulse not tied to commit");
    a_commit_low_byte: assert property (commit |=> frac_word[7:0] == $past(reg_req.wdata))
        else $error("commit byte not active");
    a_actives_hold: assert property (!cfg_update |-> $stable(frac_word) && $stable(int_word))
        else $error("active word moved without commit");
    a_pump_decode: assert property (pump_level_100na == (16'h0001 + pump_code) * 16'h0C35)
        else $error("pump level mismatch");
    a_ratio_decode: assert property (ref_div_ratio ==
        (!ref_div_enable ? 6'h01 : ref_div_code == 5'h00 ? 6'h20 : {1'h0, ref_div_code}))
        else $error("divider ratio mismatch");
    a_drive_high: assert property (sel_high ##1 !(reg_req.wr && reg_req.addr == ADDR_INTHI)
        |=> test_out && test_out_oe) else $error("test pin not driven high");
    c_commit: cover property (commit);
    c_ratio_max: cover property (ref_div_ratio == 6'h20);
    c_drive_high: cover property (sel_high);
endmodule : cfg_bank_checker

/* File: sim/host_model.sv */
// Host controller model driving the register strobe group
`timescale 1ns/1ps
module host_model (
    input  wire logic                             sys_clk,
    output synth_cfg_pkg::reg_req_t               reg_req,
    input  wire logic [synth_cfg_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic                             reg_rvalid
);
    import synth_cfg_pkg::*;
    logic [DATA_W-1:0] last_rd;
    initial reg_req = '0;
    // One-cycle strobe; released lines show inverted junk so stale values never pass
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk) #1;
        reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge sys_clk) #1;
        last_rd = reg_rdata;
        reg_req = '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~d};
    endtask : access
    // Every buffered byte except the commit byte, reserved bits written as zero
    task automatic load_shadow(input cfg_t c);
        access(1'h1, ADDR_FRAC1, c.frac[15:8]);
        access(1'h1, ADDR_FRAC2, c.frac[23:16]);
        access(1'h1, ADDR_FRAC3, {7'h00, c.frac[24]});
        access(1'h1, ADDR_RDIVEN, {3'h0, c.rdiv_en, 4'h0});
        access(1'h1, ADDR_INTLO, c.integ[7:0]);
        access(1'h1, ADDR_INTHI, {4'h0, c.integ[11:8]});
        access(1'h1, ADDR_PUMP, {c.pump, 4'h0});
        access(1'h1, ADDR_REFCTL, {1'h0, c.halver, c.doubler, c.rdiv});
    endtask : load_shadow
endmodule : host_model

/* File: sim/tb.sv */
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
module tb;
    import synth_cfg_pkg::*;
    logic        sys_clk, rst, ref_clk_in, feedback_divider_clock, reg_rvalid;
    logic        ref_div_enable, ref_halver_en, ref_doubler_en, cfg_update, test_out, test_out_oe;
    logic [7:0]  reg_rdata;
    logic [24:0] frac_word;
    logic [11:0] int_word;
    logic [3:0]  pump_code;
    logic [15:0] pump_level_100na;
    logic [4:0]  ref_div_code;
    logic [5:0]  ref_div_ratio;
    reg_req_t    reg_req;
    cfg_t        c, prev;
    int          bad_count, n_checks;
    logic        half_seen;
    logic [3:0]  codes [6] = '{4'h0, 4'h1, 4'h2, 4'hD, 4'hE, 4'h3};
    synth_divider_config_bank DUT (.sys_clk, .rst, .reg_req, .reg_rdata, .reg_rvalid,
        .frac_word, .int_word, .pump_code, .pump_level_100na, .ref_div_enable, .ref_div_code,
        .ref_div_ratio, .ref_halver_en, .ref_doubler_en, .cfg_update, .ref_clk_in,
        .feedback_divider_clock, .test_out, .test_out_oe);
    host_model HOST (.sys_clk, .reg_req, .reg_rdata, .reg_rvalid);
    initial begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end
    // Reference toggles every cycle, feedback at half rate, to exercise the halved modes
    always @(posedge sys_clk) begin
        ref_clk_in <= #1 ~ref_clk_in;
        feedback_divider_clock <= #1 feedback_divider_clock ^ ref_clk_in;
    end
    function automatic logic [15:0] exp_level(input logic [3:0] p);
        return (16'h0001 + p) * 16'h0C35;
    endfunction : exp_level
    function automatic logic [5:0] exp_ratio(input logic e, input logic [4:0] d);
        return !e ? 6'h01 : (d == 5'h00 ? 6'h20 : {1'h0, d});
    endfunction : exp_ratio
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    // All active outputs against one configuration set
    task automatic chk_cfg(input cfg_t e);
        chk("frac_word", frac_word, e.frac);
        chk("int_word", int_word, e.integ);
        chk("pump_div", {pump_code, ref_div_code}, {e.pump, e.rdiv});
        chk("pump_level", pump_level_100na, exp_level(e.pump));
        chk("div_enable", ref_div_enable, e.rdiv_en);
        chk("div_ratio", ref_div_ratio, exp_ratio(e.rdiv_en, e.rdiv));
        chk("ref_path", {ref_halver_en, ref_doubler_en}, {e.halver, e.doubler});
    endtask : chk_cfg
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
    // Hang guard: far beyond the roughly 500 cycles the sequence needs
    initial begin
        #200000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        rst = 1'h1;
        ref_clk_in = 1'h0;
        feedback_divider_clock = 1'h0;
        prev = '0;
        void'($urandom(32'hB688B3ED));
        repeat (12) @(posedge sys_clk);
        #1 rst = 1'h0;
        chk_cfg('0);
        chk("oe_reset", test_out_oe, 1'h0);
        $display("test reset done");
        // Corners first (ratio 32, ratio 31, bypass), then random sets
        for (int i = 0; i < 20; i++) begin
            c = 49'({$urandom, $urandom});
            if (i < 3) begin
                c = '0;
                c.rdiv_en = (i != 2);
                c.rdiv = (i == 1) ? 5'h1F : 5'h00;
                c.pump = (i == 0) ? 4'hF : 4'h0;
            end
            HOST.load_shadow(c);
            chk_cfg(prev);
            HOST.access(1'h1, ADDR_FRAC0, c.frac[7:0]);
            chk("update", cfg_update, 1'h1);
            chk_cfg(c);
            HOST.access(1'h0, ADDR_FRAC3, 8'h00);
            chk("rd_frac3", HOST.last_rd, {7'h00, c.frac[24]});
            HOST.access(1'h0, ADDR_REFCTL, 8'h00);
            chk("rd_refctl", HOST.last_rd, {1'h0, c.halver, c.doubler, c.rdiv});
            prev = c;
        end
        $display("test commit done");
        // Every selector code plus an unlisted one, which must float the pin
        foreach (codes[k]) begin
            HOST.access(1'h1, ADDR_INTHI, {codes[k], 4'h0});
            @(posedge sys_clk) #1;
            chk("test_oe", test_out_oe, codes[k] inside {4'h1, 4'h2, 4'hD, 4'hE});
            if (codes[k] inside {4'h1, 4'h2}) begin
                chk("test_out", test_out, codes[k] == 4'h1);
            end
            // Reference rises every 2 cycles, feedback every 4: one pin toggle per span
            if (codes[k] inside {4'hD, 4'hE}) begin
                half_seen = test_out;
                repeat ((codes[k] == 4'hD) ? 2 : 4) @(posedge sys_clk);
                #1 chk("test_half", test_out, !half_seen);
            end
        end
        $display("test selector done");
        // Unmapped offset and reserved bits read back as zero
        HOST.access(1'h1, 8'h04, 8'hFF);
        HOST.access(1'h0, 8'h04, 8'h00);
        chk("rd_unmapped", HOST.last_rd, 8'h00);
        HOST.access(1'h1, ADDR_PUMP, 8'hFF);
        HOST.access(1'h0, ADDR_PUMP, 8'h00);
        chk("rd_pump_rsv", HOST.last_rd, 8'hF0);
        $display("test reserved done");
        // Reset in mid-run clears the actives again
        rst = 1'h1;
        repeat (3) @(posedge sys_clk);
        #1 rst = 1'h0;
        chk_cfg('0);
        // Pending pump shadow from before the reset must be gone too
        HOST.access(1'h0, ADDR_PUMP, 8'h00);
        chk("rd_pump_reset", HOST.last_rd, 8'h00);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule : tb
bind synth_divider_config_bank cfg_bank_checker u_chk (.sys_clk, .rst, .reg_req, .reg_rdata,
    .reg_rvalid, .frac_word, .int_word, .pump_code, .pump_level_100na, .ref_div_enable,
    .ref_div_code, .ref_div_ratio, .cfg_update, .test_out, .test_out_oe);
